// ==== dv/pmw_osc_model.sv ====
/*
 Behavioural fast and slow oscillators.
 Assumes the run enables come from the sequencer; a stopped source rests low.
*/
`timescale 1ns/1ps
`default_nettype none

module pmw_osc_model
(
	// Enables
	input wire logic fastRun,
	input wire logic slowRun,
	// Oscillator clocks
	output logic fastTick,
	output logic slowTick
);
	initial fastTick = 1'h0;
	initial slowTick = 1'h0;
	// Periods unrelated to the system clock on purpose
	always #230 fastTick = fastRun ? ~fastTick : 1'h0;
	always #370 slowTick = slowRun ? ~slowTick : 1'h0;
endmodule // pmw_osc_model
`default_nettype wire

// ==== dv/pmw_power_mode_sva.sv ====
/*
 Port checker for the power-mode sequencer.
 Assumes one clock domain and a synchronous active-high reset.
*/
`timescale 1ns/1ps
`default_nettype none

module pmw_power_mode_sva
	import pmw_pkg::*;
(
	// Clock and reset
	input wire logic clk,
	input wire logic sys_rst,
	// APB
	input wire logic psel,
	input wire logic penable,
	input wire logic pslverr,
	input wire logic pready,
	// CPU core
	input wire logic stopExec,
	input wire logic clrWdtExec,
	input wire logic cpuHold,
	input wire logic resumeAfterStop,
	input wire logic irqResponse,
	input wire logic resetPcSp,
	input wire logic wdtClear,
	// Clocks
	input wire logic slowOscRun,
	input wire logic [2:0] sysClkSelect,
	input wire logic sysClkOnSub,
	input wire logic sysClkRun
);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (sys_rst);

	chk_stop_halts: assert property (
		stopExec && !cpuHold |=> cpuHold && !sysClkRun)
		else $error("stop did not halt");
	chk_stop_wdclr: assert property (
		stopExec && !cpuHold |-> wdtClear)
		else $error("stop did not clear watchdog");
	chk_clr_wdclr: assert property (
		clrWdtExec |-> wdtClear)
		else $error("clear did not clear watchdog");
	chk_wake_single: assert property (
		$onehot0({resumeAfterStop, irqResponse, resetPcSp}))
		else $error("two wake outcomes at once");
	chk_wake_release: assert property (
		resumeAfterStop || irqResponse || resetPcSp |->
		!cpuHold && $past(cpuHold))
		else $error("hold not released with wake");
	chk_hold_keeps: assert property (
		cpuHold |=> cpuHold || resumeAfterStop || irqResponse || resetPcSp)
		else $error("hold dropped without wake");
	chk_sub_code: assert property (
		sysClkOnSub |->
		$past(sysClkSelect) == 3'h7 && sysClkRun && slowOscRun)
		else $error("sub clock without its code");
	chk_fast_code: assert property (
		sysClkRun && !stopExec && sysClkSelect != 3'h7 |=>
		sysClkRun && !sysClkOnSub)
		else $error("fast code left sub clock on");
	chk_err_phase: assert property (
		pslverr |-> psel && penable)
		else $error("error outside access phase");
	chk_ready_access: assert property (
		psel && penable |-> pready)
		else $error("access phase without ready");
endmodule // pmw_power_mode_sva

bind pmw_power_mode pmw_power_mode_sva u_sva (.clk(clk), .sys_rst(sys_rst),
	.psel(psel), .penable(penable), .pslverr(pslverr), .pready(pready),
	.stopExec(stopExec),
	.clrWdtExec(clrWdtExec), .cpuHold(cpuHold), .wdtClear(wdtClear),
	.resumeAfterStop(resumeAfterStop), .irqResponse(irqResponse),
	.resetPcSp(resetPcSp), .slowOscRun(slowOscRun), .sysClkRun(sysClkRun),
	.sysClkSelect(sysClkSelect), .sysClkOnSub(sysClkOnSub));
`default_nettype wire

// ==== dv/tb_top.sv ====
/*
 Self-checking bench for the power-mode sequencer.
 Assumes the oscillator model and the bound port checker.
*/
`timescale 1ns/1ps
`default_nettype none
`include "pmw_defines.svh"

module tb_top
	import pmw_pkg::*;
;
	logic clk, sys_rst, psel, penable, pwrite, pready, pslverr;
	logic stopExec, clrWdtExec, cpuHold, resumeAfterStop, irqResponse;
	logic resetPcSp, fastOscTick, slowOscTick, fastOscRun, slowOscRun;
	logic sysClkOnSub, sysClkRun, wdtOverflow, wdtClear, wdtRun, stackFull;
	logic [2:0] sysClkSelect;
	logic [7:0] portAPin, irqRequest, irqEnable;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, r;
	logic e;
	logic [2:0] got;
	int err_total, num_checks, cyc;
	localparam logic [11:0] A_CLK = `PMW_ADDR_CLK_CTRL;
	localparam logic [11:0] A_OSC = `PMW_ADDR_OSC_CTRL;
	localparam logic [11:0] A_ST = `PMW_ADDR_STATUS;

	always #50 clk = ~clk;

	pmw_osc_model u_osc (.fastRun(fastOscRun), .slowRun(slowOscRun),
		.fastTick(fastOscTick), .slowTick(slowOscTick));
	pmw_power_mode u_dut (.clk(clk), .sys_rst(sys_rst), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr),
		.stopExec(stopExec), .clrWdtExec(clrWdtExec), .cpuHold(cpuHold),
		.resumeAfterStop(resumeAfterStop), .irqResponse(irqResponse),
		.resetPcSp(resetPcSp), .fastOscTick(fastOscTick),
		.slowOscTick(slowOscTick), .fastOscRun(fastOscRun),
		.slowOscRun(slowOscRun), .sysClkSelect(sysClkSelect),
		.sysClkOnSub(sysClkOnSub), .sysClkRun(sysClkRun),
		.wdtOverflow(wdtOverflow), .wdtClear(wdtClear), .wdtRun(wdtRun),
		.portAPin(portAPin), .irqRequest(irqRequest), .irqEnable(irqEnable),
		.stackFull(stackFull));

	task check(input logic [31:0] seen, input logic [31:0] want, string m);
		num_checks++;
		if (seen !== want)
		begin
			err_total++;
			$display("BAD %0t %s seen %h want %h", $time, m, seen, want);
		end
	endtask

	task settle;
		@(posedge clk);
		#1;
	endtask

	// Holds the request until pready is sampled high
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge clk);
		{psel, penable, pwrite, paddr, pwdata} <= {2'h2, w, a, d};
		@(posedge clk);
		penable <= 1'h1;
		@(posedge clk);
		while (pready !== 1'h1)
			@(posedge clk);
		r = prdata;
		e = pslverr;
		{psel, penable} <= 2'h0;
	endtask

	task do_stop;
		@(posedge clk);
		stopExec <= 1'h1;
		@(posedge clk);
		stopExec <= 1'h0;
		settle();
	endtask

	task wake_wait(input int lim);
		got = 3'h0;
		for (int i = 0; i < lim && got == 3'h0; i++)
		begin
			settle();
			got = {resumeAfterStop, irqResponse, resetPcSp};
		end
	endtask

	task pin_wake(input int p);
		@(posedge clk);
		portAPin[p] <= 1'h0;
		wake_wait(400);
		check(32'(got), 32'h4, "pin wake");
		@(posedge clk);
		portAPin <= 8'hff;
	endtask

	task t_reset;
		settle();
		check(32'(sysClkSelect), 32'h2, "select");
		apb(1'h0, A_CLK, 32'h0);
		check(r, 32'h40, "clk ctrl");
		apb(1'h0, A_ST, 32'h0);
		check(r & 32'h73, 32'h0, "status");
	endtask

	task t_clock;
		logic [2:0] c;
		for (int i = 0; i < 9; i++)
		begin
			c = 3'(i + 7);
			apb(1'h1, A_CLK, 32'(c) << 5);
			settle();
			for (int j = 0; j < 300 && c == 3'h7 &&
				sysClkOnSub !== 1'h1; j++)
				settle();
			check(32'(sysClkSelect), 32'(c), "select");
			check(32'(sysClkOnSub), 32'(c == 3'h7), "on sub");
			if (c == 3'h7)
			begin
				apb(1'h1, A_OSC, 32'h0);
				apb(1'h1, A_OSC, 32'h1);
				apb(1'h0, A_OSC, 32'h0);
				check(r & 32'h3, 32'h1, "stable cleared");
				for (int j = 0; j < 60 && r[1] !== 1'h1; j++)
					apb(1'h0, A_OSC, 32'h0);
				check(r & 32'h3, 32'h3, "stable set");
			end
		end
	endtask

	task t_modes;
		pmw_mode_t m;
		apb(1'h1, `PMW_ADDR_WAKE_EN, 32'hff);
		for (int k = 0; k < 4; k++)
		begin
			m = k == 0 ? PMW_SLEEP : k == 1 ? PMW_IDLE_SLOW_ONLY :
				k == 2 ? PMW_IDLE_FAST_ONLY : PMW_IDLE_BOTH;
			apb(1'h1, A_CLK, 32'(k));
			do_stop();
			check(32'(fastOscRun), 32'(k[1]), "fast in stop");
			apb(1'h1, A_CLK, 32'(3 - k));
			apb(1'h0, A_ST, 32'h0);
			check(r & 32'h73, (32'(m) << 4) | 32'h1, "stop status");
			pin_wake(k);
			apb(1'h0, A_CLK, 32'h0);
			check(r, 32'(3 - k), "regs kept");
			apb(1'h0, A_ST, 32'h0);
			check(r & 32'h73, 32'h1, "flag kept");
			@(posedge clk);
			clrWdtExec <= 1'h1;
			@(posedge clk);
			clrWdtExec <= 1'h0;
			apb(1'h0, A_ST, 32'h0);
			check(r & 32'h3, 32'h0, "flag cleared");
		end
	endtask

	task t_irq;
		apb(1'h1, A_CLK, 32'h3);
		@(posedge clk);
		{irqEnable, irqRequest} <= 16'h0f01;
		do_stop();
		wake_wait(60);
		check(32'(got), 32'h0, "stale irq");
		@(posedge clk);
		irqRequest <= 8'h03;
		wake_wait(400);
		check(32'(got), 32'h2, "irq serviced");
		for (int k = 0; k < 2; k++)
		begin
			@(posedge clk);
			{irqEnable, irqRequest, stackFull} <= {k ? 8'h0 : 8'h04, 8'h0, k == 0};
			do_stop();
			@(posedge clk);
			irqRequest <= 8'h04;
			wake_wait(400);
			check(32'(got), 32'h4, "irq resume");
		end
		@(posedge clk);
		{irqRequest, stackFull} <= 9'h0;
	endtask

	task t_wdt;
		apb(1'h1, A_CLK, 32'h0);
		do_stop();
		@(posedge clk);
		wdtOverflow <= 1'h1;
		@(posedge clk);
		wdtOverflow <= 1'h0;
		wake_wait(400);
		check(32'(got), 32'h1, "wdt wake");
		apb(1'h0, A_ST, 32'h0);
		check(r & 32'h3, 32'h3, "wdt flags");
		do_stop();
		apb(1'h0, A_ST, 32'h0);
		check(r & 32'h3, 32'h1, "timeout cleared");
		pin_wake(0);
		apb(1'h0, 12'h020, 32'h0);
		check({r[30:0], e}, 32'h1, "unmapped read");
		apb(1'h1, 12'h020, 32'hffffffff);
		check(32'(e), 32'h1, "unmapped write");
	endtask

	task t_rerun;
		apb(1'h1, `PMW_ADDR_WDT_CTRL, 32'h0);
		settle();
		check(32'(wdtRun), 32'h0, "wdt stopped");
		do_stop();
		check(32'(slowOscRun), 32'h0, "sleep slow off");
		@(posedge clk);
		sys_rst <= 1'h1;
		repeat (2) @(posedge clk);
		sys_rst <= 1'h0;
		settle();
		check(32'(cpuHold), 32'h0, "reset leaves stop");
		check(32'(sysClkSelect), 32'h2, "select reset");
		apb(1'h0, A_ST, 32'h0);
		check(r & 32'h73, 32'h0, "power-up clear");
		check(32'(wdtRun), 32'h1, "wdt reset on");
	endtask

	task test_done;
		$display("checks %0d mismatches %0d", num_checks, err_total);
		if (err_total == 0 && num_checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	always @(posedge clk)
	begin
		cyc <= cyc + 1;
		if (cyc == 20000)
		begin
			err_total++;
			test_done();
		end
	end

	initial
	begin
		{clk, psel, penable, pwrite, stopExec, clrWdtExec} = 6'h0;
		{wdtOverflow, stackFull, paddr, pwdata, irqRequest, irqEnable} = '0;
		sys_rst = 1'h1;
		portAPin = 8'hff;
		repeat (6) @(posedge clk);
		sys_rst <= 1'h0;
		t_reset();
		t_clock();
		t_modes();
		t_irq();
		t_wdt();
		t_rerun();
		test_done();
	end
endmodule // tb_top
`default_nettype wire

// ==== pkg/pmw_defines.svh ====
/*
 Power-mode sequencer constants: clock select codes, reset values, counts.
 Assumes inclusion by bare name from the package and the design files.
*/
`ifndef PMW_DEFINES_SVH
`define PMW_DEFINES_SVH

// ----------------------------------------------------------------
// Clock select
// ----------------------------------------------------------------
`define PMW_CKS_SLOW 3'h7
`define PMW_CKS_RESET 3'h2
`define PMW_CKS_W 3

// ----------------------------------------------------------------
// Oscillator stabilisation
// ----------------------------------------------------------------
`define PMW_FAST_STABLE_CLOCKS 16
`define PMW_SLOW_STABLE_CLOCKS 16
`define PMW_FAST_EN_RESET 1'h1

// ----------------------------------------------------------------
// Register offsets (byte addresses on APB)
// ----------------------------------------------------------------
`define PMW_ADDR_CLK_CTRL 12'h000
`define PMW_ADDR_OSC_CTRL 12'h004
`define PMW_ADDR_STATUS 12'h008
`define PMW_ADDR_WAKE_EN 12'h00c
`define PMW_ADDR_WDT_CTRL 12'h010

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define PMW_CKS_LSB 5
`define PMW_FHK_BIT 1
`define PMW_FSK_BIT 0
`define PMW_FSTB_BIT 1
`define PMW_FEN_BIT 0
`define PMW_PDF_BIT 0
`define PMW_TO_BIT 1
`define PMW_MODE_LSB 4
`define PMW_SLOWRDY_BIT 2

`endif

// ==== pkg/pmw_pkg.sv ====
/*
 Power-mode sequencer types.
 Assumes pmw_defines.svh is on the include path.
*/
package pmw_pkg;
`include "pmw_defines.svh"

	// ----------------------------------------------------------------
	// Operating modes
	// ----------------------------------------------------------------
	typedef enum logic [2:0]
	{
		PMW_FAST = 3'h0,
		PMW_SLOW = 3'h1,
		PMW_SLEEP = 3'h2,
		PMW_IDLE_SLOW_ONLY = 3'h3,
		PMW_IDLE_BOTH = 3'h4,
		PMW_IDLE_FAST_ONLY = 3'h5,
		PMW_WAKE = 3'h6
	} pmw_mode_t;

	// ----------------------------------------------------------------
	// Wake causes
	// ----------------------------------------------------------------
	typedef enum logic [1:0]
	{
		PMW_WK_NONE = 2'h0,
		PMW_WK_PIN = 2'h1,
		PMW_WK_IRQ = 2'h2,
		PMW_WK_WDT = 2'h3
	} pmw_wake_t;
endpackage

// ==== rtl/pmw_osc_stable.sv ====
/*
 Oscillator stable timer: counts enabled clocks of a source and
 raises a stable flag once the count is reached.
 Assumes oscTick is a one-cycle pulse per oscillator clock.
*/
`timescale 1ns/1ps
`default_nettype none

module pmw_osc_stable
	import pmw_pkg::*;
#(
	parameter int COUNT = 16
)
(
	// Clock and reset
	input wire logic clk,
	input wire logic sys_rst,
	// Oscillator
	input wire logic oscEnable,
	input wire logic oscTick,
	// Status
	output logic stable
);
	localparam int CW = $clog2(COUNT + 1);

	initial
	begin
		if (COUNT < 1)
			$error("pmw_osc_stable: COUNT must be at least 1");
	end

	logic [CW-1:0] count;
	wire atEnd = (count == CW'(COUNT));

	// ----------------------------------------------------------------
	// Counter
	// ----------------------------------------------------------------
	// Disabled source drops the flag at once, so a restart starts low
	always_ff @(posedge clk)
	begin
		if (sys_rst || !oscEnable)
			count <= '0;
		else if (oscTick && !atEnd)
			count <= count + CW'(1);
	end

	always_ff @(posedge clk)
	begin
		if (sys_rst || !oscEnable)
			stable <= 1'b0;
		else
			stable <= atEnd;
	end
endmodule // pmw_osc_stable

`default_nettype wire

// ==== rtl/pmw_power_mode.sv ====
/*
 Power-mode and wake-up sequencer with APB register access.
 Assumes the CPU pulses stopExec and clrWdtExec, oscillator ticks and
 port pins come from outside the clock domain, and interrupt logic
 gives per-source request, enable and a stack-full level.
*/
// Our own choices: the placing of the registers and the APB interface to the registers.
// Function
// - Clock select 111 in FAST moves the system clock to the sub clock.
// - Codes 000..110 pick fast clock divided 1..64, giving FAST mode.
// - SLOW mode completes only once the slow oscillator is stable.
// - Stop with both keep bits low enters SLEEP; fast clock off, slow clock off unless watchdog enabled or select 111.
// - Stop with fast keep 0, slow keep 1 enters slow-only idle.
// - Stop with both keep bits high enters idle with both clocks.
// - Stop with fast keep 1, slow keep 0 enters fast-only idle.
// - Execution halts at stop; memory, registers and ports hold.
// - Entering any stop mode sets power-down, clears time-out flag.
// - Stop entry clears watchdog; it counts on only if enabled.
// - Wake on enabled port falling edge, interrupt or watchdog overflow.
// - Power-down flag clears only at power-up or clear-watchdog.
// - Watchdog wake sets time-out, resets only PC and stack pointer.
// - Each port pin has a wake enable; pin wake resumes after stop.
// - Disabled or stack-full interrupt wake resumes after stop, pends.
// - Enabled interrupt with stack room takes normal interrupt response.
// - A request already pending before stop cannot wake the device.
// - Stopping the fast oscillator clears its stable flag; it sets after 16 clocks of running.
`timescale 1ns/1ps
`default_nettype none

module pmw_power_mode
	import pmw_pkg::*;
#(
	parameter int PORT_W = 8,
	parameter int IRQ_W = 8
)
(
	// Clock and reset
	input wire logic clk,
	input wire logic sys_rst,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// CPU core
	input wire logic stopExec,
	input wire logic clrWdtExec,
	output logic cpuHold,
	output logic resumeAfterStop,
	output logic irqResponse,
	output logic resetPcSp,
	// Oscillators
	input wire logic fastOscTick,
	input wire logic slowOscTick,
	output logic fastOscRun,
	output logic slowOscRun,
	output logic [2:0] sysClkSelect,
	output logic sysClkOnSub,
	output logic sysClkRun,
	// Watchdog
	input wire logic wdtOverflow,
	output logic wdtClear,
	output logic wdtRun,
	// Port A and interrupts
	input wire logic [PORT_W-1:0] portAPin,
	input wire logic [IRQ_W-1:0] irqRequest,
	input wire logic [IRQ_W-1:0] irqEnable,
	input wire logic stackFull
);
`include "pmw_defines.svh"

	initial
	begin
		if (PORT_W < 1 || PORT_W > 16 || IRQ_W < 1 || IRQ_W > 16)
			$error("pmw_power_mode: PORT_W and IRQ_W must be 1..16");
	end

	// ----------------------------------------------------------------
	// Registers
	// ----------------------------------------------------------------
	logic [2:0] sys_clk_select;
	logic fast_osc_keep_on_stop;
	logic slow_osc_keep_on_stop;
	logic fastOscEnable;
	logic wdtEnable;
	logic power_down_flag;
	logic timeout_flag;
	logic [PORT_W-1:0] port_a_wake_enable;
	logic [IRQ_W-1:0] irqArmed;
	pmw_mode_t mode;
	pmw_mode_t next_mode;
	pmw_wake_t wakeCause;

	// ----------------------------------------------------------------
	// Pin synchronisers: change counts when stages two and three agree
	// ----------------------------------------------------------------
	logic [PORT_W-1:0] pinS1, pinS2, pinS3, pinLevel;
	logic [3:0] fTickS, sTickS;
	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			pinS1 <= '1;
			pinS2 <= '1;
			pinS3 <= '1;
			pinLevel <= '1;
			fTickS <= 4'h0;
			sTickS <= 4'h0;
		end
		else
		begin
			pinS1 <= portAPin;
			pinS2 <= pinS1;
			pinS3 <= pinS2;
			pinLevel <= (pinS2 & pinS3) | (pinLevel & ~(~pinS2 & ~pinS3));
			fTickS <= {fTickS[2:0], fastOscTick};
			sTickS <= {sTickS[2:0], slowOscTick};
		end
	end
	// Tick once stages two and three agree high; stage four is history
	wire fastTick = fTickS[1] & fTickS[2] & ~fTickS[3];
	wire slowTick = sTickS[1] & sTickS[2] & ~sTickS[3];
	wire [PORT_W-1:0] nextLevel = (pinS2 & pinS3) |
		(pinLevel & ~(~pinS2 & ~pinS3));
	wire [PORT_W-1:0] pinFall = pinLevel & ~nextLevel;

	// ----------------------------------------------------------------
	// Mode decode
	// ----------------------------------------------------------------
	wire inStop = (mode == PMW_SLEEP) || (mode == PMW_IDLE_SLOW_ONLY) ||
		(mode == PMW_IDLE_BOTH) || (mode == PMW_IDLE_FAST_ONLY);
	wire runMode = (mode == PMW_FAST) || (mode == PMW_SLOW);
	wire stopTake = runMode && stopExec;
	wire wantSlow = (sys_clk_select == `PMW_CKS_SLOW);

	// Oscillator stable timers
	wire fastStable;
	wire slowStable;
	wire fastRunNow = fastOscRun;
	pmw_osc_stable #(.COUNT(`PMW_FAST_STABLE_CLOCKS)) u_fast_stable
	(
		.clk(clk),
		.sys_rst(sys_rst),
		.oscEnable(fastRunNow),
		.oscTick(fastTick),
		.stable(fastStable)
	);
	pmw_osc_stable #(.COUNT(`PMW_SLOW_STABLE_CLOCKS)) u_slow_stable
	(
		.clk(clk),
		.sys_rst(sys_rst),
		.oscEnable(slowOscRun),
		.oscTick(slowTick),
		.stable(slowStable)
	);

	// ----------------------------------------------------------------
	// Wake sources
	// ----------------------------------------------------------------
	// Only requests that rose after stop entry are armed to wake
	wire [IRQ_W-1:0] irqWake = irqRequest & irqArmed;
	wire pinWake = |(pinFall & port_a_wake_enable);
	wire anyIrq = |irqWake;
	wire irqServe = |(irqWake & irqEnable) && !stackFull;
	wire wdtWake = wdtOverflow && wdtEnable;
	wire wakeEvt = inStop && (pinWake || anyIrq || wdtWake);
	wire srcReady = wantSlow ? slowStable : fastStable;

	// ----------------------------------------------------------------
	// Next mode
	// ----------------------------------------------------------------
	always_comb
	begin
		next_mode = mode;
		case (mode)
			PMW_FAST:
				if (stopExec)
					next_mode = stopMode(fast_osc_keep_on_stop,
						slow_osc_keep_on_stop);
				else if (wantSlow && slowStable)
					next_mode = PMW_SLOW;
			PMW_SLOW:
				if (stopExec)
					next_mode = stopMode(fast_osc_keep_on_stop,
						slow_osc_keep_on_stop);
				else if (!wantSlow)
					next_mode = PMW_FAST;
			PMW_SLEEP, PMW_IDLE_SLOW_ONLY, PMW_IDLE_BOTH,
			PMW_IDLE_FAST_ONLY:
				if (wakeEvt)
					next_mode = PMW_WAKE;
			PMW_WAKE:
				if (srcReady)
					next_mode = wantSlow ? PMW_SLOW : PMW_FAST;
			default:
				next_mode = PMW_FAST;
		endcase
	end

	function automatic pmw_mode_t stopMode(input logic fk, input logic sk);
		case ({fk, sk})
			2'h0: stopMode = PMW_SLEEP;
			2'h1: stopMode = PMW_IDLE_SLOW_ONLY;
			2'h3: stopMode = PMW_IDLE_BOTH;
			default: stopMode = PMW_IDLE_FAST_ONLY;
		endcase
	endfunction

	always_ff @(posedge clk)
	begin
		if (sys_rst)
			mode <= PMW_FAST;
		else
			mode <= next_mode;
	end

	// ----------------------------------------------------------------
	// Wake bookkeeping and CPU handshakes
	// ----------------------------------------------------------------
	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			irqArmed <= '0;
			wakeCause <= PMW_WK_NONE;
			resumeAfterStop <= 1'b0;
			irqResponse <= 1'b0;
			resetPcSp <= 1'b0;
		end
		else
		begin
			irqArmed <= stopTake ? ~irqRequest : irqArmed;
			if (wakeEvt)
				wakeCause <= wdtWake ? PMW_WK_WDT :
					(anyIrq && irqServe) ? PMW_WK_IRQ : PMW_WK_PIN;
			resumeAfterStop <= 1'b0;
			irqResponse <= 1'b0;
			resetPcSp <= 1'b0;
			if (mode == PMW_WAKE && srcReady)
			begin
				resetPcSp <= (wakeCause == PMW_WK_WDT);
				irqResponse <= (wakeCause == PMW_WK_IRQ);
				resumeAfterStop <= (wakeCause == PMW_WK_PIN);
			end
		end
	end

	// ----------------------------------------------------------------
	// Status flags; set wins over clear
	// ----------------------------------------------------------------
	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			power_down_flag <= 1'b0;
			timeout_flag <= 1'b0;
		end
		else
		begin
			if (stopTake)
				power_down_flag <= 1'b1;
			else if (clrWdtExec)
				power_down_flag <= 1'b0;
			if (inStop && wdtWake)
				timeout_flag <= 1'b1;
			else if (stopTake || clrWdtExec)
				timeout_flag <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// APB registers
	// ----------------------------------------------------------------
	wire wrEn = psel && penable && pwrite;
	wire selClk = (paddr == `PMW_ADDR_CLK_CTRL);
	wire selOsc = (paddr == `PMW_ADDR_OSC_CTRL);
	wire selSts = (paddr == `PMW_ADDR_STATUS);
	wire selWake = (paddr == `PMW_ADDR_WAKE_EN);
	wire selWdt = (paddr == `PMW_ADDR_WDT_CTRL);
	wire mapped = selClk | selOsc | selSts | selWake | selWdt;

	// Writes are taken in every mode, including while the CPU is halted
	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			sys_clk_select <= `PMW_CKS_RESET;
			fast_osc_keep_on_stop <= 1'b0;
			slow_osc_keep_on_stop <= 1'b0;
			fastOscEnable <= `PMW_FAST_EN_RESET;
			port_a_wake_enable <= '0;
			wdtEnable <= 1'b1;
		end
		else if (wrEn)
		begin
			if (selClk)
			begin
				sys_clk_select <= pwdata[`PMW_CKS_LSB +: 3];
				fast_osc_keep_on_stop <= pwdata[`PMW_FHK_BIT];
				slow_osc_keep_on_stop <= pwdata[`PMW_FSK_BIT];
			end
			if (selOsc)
				fastOscEnable <= pwdata[`PMW_FEN_BIT];
			if (selWake)
				port_a_wake_enable <= pwdata[PORT_W-1:0];
			if (selWdt)
				wdtEnable <= pwdata[0];
		end
	end

	wire [31:0] rdClk = {24'h0, sys_clk_select, 3'h0,
		fast_osc_keep_on_stop, slow_osc_keep_on_stop};
	wire [31:0] rdOsc = {30'h0, fastStable, fastOscEnable};
	wire [31:0] rdSts = {25'h0, mode, 1'b0, slowStable, timeout_flag,
		power_down_flag};
	wire [31:0] rdWake = {{(32-PORT_W){1'b0}}, port_a_wake_enable};
	wire [31:0] rdWdt = {31'h0, wdtEnable};
	wire [31:0] rdMux = selClk ? rdClk : selOsc ? rdOsc : selSts ? rdSts :
		selWake ? rdWake : selWdt ? rdWdt : 32'h0;

	always_ff @(posedge clk)
	begin
		if (sys_rst)
			prdata <= 32'h0;
		else if (psel && !penable && !pwrite)
			prdata <= rdMux;
	end

	assign pready = 1'b1;
	assign pslverr = psel && penable && !mapped;

	// ----------------------------------------------------------------
	// Clock and watchdog outputs
	// ----------------------------------------------------------------
	// Fast source off in SLEEP and slow-only idle, and in SLOW if disabled
	assign fastOscRun = fastOscEnable && (mode != PMW_SLEEP) &&
		(mode != PMW_IDLE_SLOW_ONLY) || (mode == PMW_WAKE && !wantSlow)
		|| (mode == PMW_FAST);
	assign slowOscRun = (mode != PMW_SLEEP && mode != PMW_IDLE_FAST_ONLY)
		|| wdtRun || wantSlow;
	assign sysClkSelect = sys_clk_select;
	assign sysClkOnSub = (mode == PMW_SLOW);
	assign sysClkRun = runMode;
	assign cpuHold = !runMode;
	assign wdtClear = stopTake || clrWdtExec;
	assign wdtRun = wdtEnable;
endmodule // pmw_power_mode

`default_nettype wire
